/* File: eeprom_cfg_pkg.sv */
// shared constants and types for the serial eeprom select and write-lock front end
package eeprom_cfg_pkg;

	// configuration byte layout
	localparam int CFG_LOCK_POS = 0;
	localparam int CFG_ADDR_LSB = 1;
	localparam int CFG_ADDR_MSB = 3;
	localparam logic [2:0] CFG_ADDR_FACTORY = 3'h0;
	localparam logic CFG_LOCK_FACTORY = 1'h0;

	// select code layout
	localparam int SEL_TYPE_MSB = 7;
	localparam int SEL_TYPE_LSB = 4;
	localparam int SEL_CE_MSB = 3;
	localparam int SEL_CE_LSB = 1;
	localparam int SEL_RW_POS = 0;
	localparam logic SEL_RW_READ = 1'h1;

	// address high byte: top bit selects the configuration byte
	localparam int ADDR_CFG_SEL_POS = 7;

	// bit slot counter
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// internal write cycle time
	localparam int unsigned WRITE_TIME_NS = 5000000;
	localparam int unsigned CORE_CLK_NS = 40;
	localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_NS / CORE_CLK_NS;

	typedef struct packed {
		logic [2:0] addr;
		logic lock;
	} cfg_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SELECT,
		ST_ADDR_HIGH,
		ST_ADDR_LOW,
		ST_DATA,
		ST_READ
	} link_state_type;

endpackage

/* File: eeprom_select_lock.sv */
// serial eeprom slave front end: start/stop, select code match, acknowledge, write lock
`timescale 1ns/100ps

// Overview of operation
// - acknowledge select code only when chip enable bits equal stored address
// - on match, pull data low during ninth bit slot
// - on no acknowledge, deselect and idle until next start
// - eighth select bit: one means read, zero means write
// - start is data falling while clock high
// - start always watched; select refused during internal write cycle
// - stop is data rising while clock high; ends communication
// - stop closing a write instruction launches internal write cycle
// - read byte not acknowledged by master returns device to standby
// - data sampled on each rising clock edge
// - data changes only while clock low, stable across rising edge
// - after eight bits transmitter releases, receiver acknowledges on ninth
// - stored address bits form expected chip enable field, rewritable by write
// - stored address loaded at power-up and after reprogramming; factory zero
// - lock bit one refuses array writes; zero allows; factory zero
// - lock bit restored at power-up from stored value; reset here loads factory zero instead
// - lock bit changeable either direction any number of times
// - with lock set, select and address acknowledged, array data bytes not; first configuration data byte still acknowledged
// - configuration byte: address bits three to one, lock bit zero
// - configuration byte selected by address top bit one
// - configuration writes accepted regardless of lock bit
// - after rewrite, only select codes with new address acknowledged
module eeprom_select_lock
	import eeprom_cfg_pkg::*;
#(
	parameter logic [3:0] DEVICE_TYPE = 4'h6, // arbitrary value
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_resetn, // async reset, active low
	input wire logic i_scl, // serial clock from master
	input wire logic i_sda, // serial data line level
	output logic o_sda_out, // data drive value, always low
	output logic o_sda_oe, // high while pulling data low
	output logic [2:0] o_cfg_addr, // active configurable_slave_address
	output logic o_array_write_lock, // active array_write_lock
	output logic o_write_busy, // internal write cycle running
	output logic o_array_write_start, // one-cycle pulse: launch array write
	output logic [7:0] o_array_write_data // last accepted data byte
);

	// elaboration-time guard: the write cycle counter is only 24 bits wide
	if (WRITE_CYCLES < 1 || WRITE_CYCLES > 32'h00ffffff) begin : bad_write_cycles
		$error("WRITE_CYCLES out of range");
	end

	function automatic logic [2:0] bit_index(input logic [3:0] cnt);
		bit_index = 3'(BIT_LAST - cnt);
	endfunction

	// start and stop events, seen on data edges while clock high
	logic start_tgl;
	logic stop_tgl;

	// the frame's own data edges carry the events, so they work while the clock stands
	always_ff @(negedge i_sda or negedge i_resetn) begin
		if (!i_resetn) begin
			start_tgl <= 1'h0;
		end else if (i_scl) begin
			start_tgl <= ~start_tgl;
		end
	end

	always_ff @(posedge i_sda or negedge i_resetn) begin
		if (!i_resetn) begin
			stop_tgl <= 1'h0;
		end else if (i_scl) begin
			stop_tgl <= ~stop_tgl;
		end
	end

	// link domain state
	link_state_type state;
	logic [3:0] bit_cnt;
	logic [6:0] shift;
	logic start_seen;
	logic stop_seen;
	logic ack_q;
	logic cfg_sel;
	logic cfg_done;
	logic pend_cfg;
	logic pend_arr;
	logic [7:0] pend_byte;
	logic [7:0] tx_byte;
	logic busy_meta;
	logic busy_link;
	cfg_type cfg_link;
	logic [7:0] rx_byte;
	logic new_start;
	logic new_stop;
	logic sel_match;

	// core domain state
	cfg_type cfg_store;
	logic [2:0] stop_sync;
	logic [1:0] pcfg_sync;
	logic [1:0] parr_sync;
	logic [23:0] wr_cnt;
	logic wr_cfg;

	assign rx_byte = {shift, i_sda};
	assign new_start = start_tgl != start_seen;
	assign new_stop = stop_tgl != stop_seen;
	// select decode; refused while the internal write cycle runs
	assign sel_match = rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEVICE_TYPE
		&& rx_byte[SEL_CE_MSB:SEL_CE_LSB] == cfg_link.addr
		&& !busy_link;

	// busy level into the link domain; settings copied only while no cycle runs
	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_meta <= 1'h0;
			busy_link <= 1'h0;
			cfg_link <= cfg_type'({CFG_ADDR_FACTORY, CFG_LOCK_FACTORY});
		end else begin
			busy_meta <= o_write_busy;
			busy_link <= busy_meta;
			if (!busy_link) begin
				cfg_link <= cfg_store;
			end
		end
	end

	// event bookkeeping
	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			start_seen <= 1'h0;
			stop_seen <= 1'h0;
		end else begin
			start_seen <= start_tgl;
			stop_seen <= stop_tgl;
		end
	end

	// bit slot counter and receive shifter, sampled on rising clock
	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			bit_cnt <= 4'h0;
			shift <= 7'h0;
		end else begin
			if (new_start || bit_cnt == BIT_ACK) begin
				bit_cnt <= new_start ? 4'h1 : 4'h0;
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
			end
			shift <= rx_byte[6:0];
		end
	end

	// byte sequencer: decisions fall on the eighth rising edge
	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
			ack_q <= 1'h0;
			cfg_sel <= 1'h0;
			cfg_done <= 1'h0;
			tx_byte <= 8'h0;
		end else if (new_start) begin
			state <= ST_SELECT;
			ack_q <= 1'h0;
			cfg_done <= 1'h0;
		end else if (new_stop) begin
			state <= ST_IDLE;
			ack_q <= 1'h0;
		end else if (bit_cnt == BIT_LAST) begin
			ack_q <= 1'h0;
			unique case (state)
				ST_IDLE: begin
					state <= ST_IDLE;
				end
				ST_SELECT: begin
					if (sel_match) begin
						ack_q <= 1'h1;
						tx_byte <= {4'h0, cfg_link.addr, cfg_link.lock};
						state <= rx_byte[SEL_RW_POS] == SEL_RW_READ ? ST_READ : ST_ADDR_HIGH;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_ADDR_HIGH: begin
					ack_q <= 1'h1;
					cfg_sel <= rx_byte[ADDR_CFG_SEL_POS];
					state <= ST_ADDR_LOW;
				end
				ST_ADDR_LOW: begin
					ack_q <= 1'h1;
					cfg_done <= 1'h0;
					state <= ST_DATA;
				end
				ST_DATA: begin
					if (cfg_sel) begin
						// a second byte aborts the configuration write
						ack_q <= !cfg_done;
						cfg_done <= 1'h1;
						state <= cfg_done ? ST_IDLE : ST_DATA;
					end else begin
						ack_q <= !cfg_link.lock;
						state <= ST_DATA;
					end
				end
				ST_READ: begin
					state <= ST_READ; // ack slot: master answers
				end
			endcase
		end else if (bit_cnt == BIT_ACK && state == ST_READ && i_sda) begin
			state <= ST_IDLE;
		end
	end

	// pending write, valid only directly after a data acknowledge
	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_cfg <= 1'h0;
			pend_arr <= 1'h0;
			pend_byte <= 8'h0;
		end else if (bit_cnt == BIT_LAST && state == ST_DATA && !new_start && !new_stop) begin
			pend_cfg <= cfg_sel && !cfg_done;
			pend_arr <= !cfg_sel && !cfg_link.lock;
			pend_byte <= rx_byte;
		end else if (bit_cnt != BIT_ACK && bit_cnt != 4'h0) begin
			// the tenth slot's own clock pulse keeps it; any later bit means the stop came too late
			pend_cfg <= 1'h0;
			pend_arr <= 1'h0;
		end
	end

	// data drive on falling clock, so it changes only while clock low
	always_ff @(negedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sda_oe <= 1'h0;
		end else if (bit_cnt == BIT_ACK) begin
			o_sda_oe <= ack_q;
		end else if (state == ST_READ) begin
			o_sda_oe <= ~tx_byte[bit_index(bit_cnt)];
		end else begin
			o_sda_oe <= 1'h0;
		end
	end

	always_ff @(posedge i_scl or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sda_out <= 1'h0;
		end else begin
			o_sda_out <= 1'h0; // open drain: only ever pulls low
		end
	end

	// stop event and pending levels into the core domain
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stop_sync <= 3'h0;
			pcfg_sync <= 2'h0;
			parr_sync <= 2'h0;
		end else begin
			stop_sync <= {stop_sync[1:0], stop_tgl};
			pcfg_sync <= {pcfg_sync[0], pend_cfg};
			parr_sync <= {parr_sync[0], pend_arr};
		end
	end

	// internal write cycle; the configuration commits as it completes
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_cnt <= 24'h0;
			wr_cfg <= 1'h0;
			o_write_busy <= 1'h0;
			o_array_write_start <= 1'h0;
			o_array_write_data <= 8'h0;
			cfg_store <= cfg_type'({CFG_ADDR_FACTORY, CFG_LOCK_FACTORY});
		end else begin
			o_array_write_start <= 1'h0;
			if (o_write_busy) begin
				if (wr_cnt == 24'h1) begin
					o_write_busy <= 1'h0;
					if (wr_cfg) begin
						cfg_store.addr <= o_array_write_data[CFG_ADDR_MSB:CFG_ADDR_LSB];
						cfg_store.lock <= o_array_write_data[CFG_LOCK_POS];
					end
				end
				wr_cnt <= wr_cnt - 24'h1;
			end else if ((stop_sync[2] != stop_sync[1]) && (pcfg_sync[1] || parr_sync[1])) begin
				o_write_busy <= 1'h1;
				wr_cnt <= 24'(WRITE_CYCLES);
				wr_cfg <= pcfg_sync[1];
				o_array_write_start <= parr_sync[1];
				o_array_write_data <= pend_byte;
			end
		end
	end

	// reported settings follow the stored byte
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cfg_addr <= CFG_ADDR_FACTORY;
			o_array_write_lock <= CFG_LOCK_FACTORY;
		end else begin
			o_cfg_addr <= cfg_store.addr;
			o_array_write_lock <= cfg_store.lock;
		end
	end

endmodule

/* File: eeprom_select_lock_props.sv */
// port checks for the select and write-lock front end
`timescale 1ns/100ps
module eeprom_select_lock_props #(parameter int unsigned WRITE_CYCLES = 20) (
	input wire logic i_core_clk, // clock
	input wire logic i_resetn, // reset
	input wire logic i_scl, // link clock
	input wire logic i_sda, // line
	input wire logic o_sda_out, // drive
	input wire logic o_sda_oe, // pull
	input wire logic [2:0] o_cfg_addr, // address
	input wire logic o_array_write_lock, // lock
	input wire logic o_write_busy, // busy
	input wire logic o_array_write_start, // launch
	input wire logic [7:0] o_array_write_data // byte
);
	int unsigned busy_cnt;
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	// busy outlasts any repetition count, so it is counted here
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			busy_cnt <= 0;
		else
			busy_cnt <= o_write_busy ? busy_cnt + 1 : 0;
	end
	sequence busy_run;
		o_write_busy [*8];
	endsequence
	a_launch_busy_run: assert property (o_array_write_start |-> o_write_busy ##1 busy_run)
		else $error("launch without busy");
	a_busy_length: assert property ($fell(o_write_busy) |-> busy_cnt == WRITE_CYCLES)
		else $error("busy length wrong");
	a_launch_single: assert property (o_array_write_start |=> !o_array_write_start)
		else $error("launch too long");
	a_locked_no_launch: assert property (o_array_write_start |-> !o_array_write_lock)
		else $error("launch while locked");
	a_no_ack_busy: assert property ($rose(o_sda_oe) |-> !o_write_busy && !$past(o_write_busy))
		else $error("answer while busy");
	a_pull_low: assert property (o_sda_oe |-> !o_sda_out && !i_sda)
		else $error("line not low");
	a_cfg_quiet: assert property (o_write_busy |=> $stable({o_cfg_addr, o_array_write_lock}))
		else $error("config moved while busy");
	// configuration writes load the byte too, so the launch is marked by busy rising
	a_data_on_launch: assert property ($changed(o_array_write_data) |-> $rose(o_write_busy))
		else $error("byte moved without launch");
endmodule
bind eeprom_select_lock eeprom_select_lock_props #(.WRITE_CYCLES(WRITE_CYCLES)) props (.*);

/* File: i2c_master_model.sv */
// bus master model: drives the serial clock and pulls the data line
`timescale 1ns/100ps
module i2c_master_model (
	output logic o_scl, // stands high between frames
	output logic o_sda_oe, // high while pulling data low
	input wire logic i_sda // resolved line, pulled up
);
	// only the master clocks the bus and opens transfers
	initial begin
		o_scl = 1'h1;
		o_sda_oe = 1'h0;
	end
	task automatic start();
		o_sda_oe = 1'h1;
		#20 o_scl = 1'h0;
	endtask
	// one 80 ns slot; data moves only while the clock is low
	task automatic slot(input logic b, output logic r);
		#10 o_sda_oe = !b;
		#30 o_scl = 1'h1;
		#30 r = i_sda;
		#10 o_scl = 1'h0;
	endtask
	// byte out msb first, then the line released for the answer
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(d[i], r);
		slot(1'h1, r);
		ack = !r;
	endtask
	// byte in, then no acknowledge to send the device to standby
	task automatic get(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			slot(1'h1, r);
			d[i] = r;
		end
		slot(1'h1, r);
	endtask
	task automatic stop();
		#10 o_sda_oe = 1'h1;
		#30 o_scl = 1'h1;
		#20 o_sda_oe = 1'h0;
		#40;
	endtask
endmodule

/* File: eeprom_select_lock_tb.sv */
// bench: select refusals, configuration writes, read back and locked writes
`timescale 1ns/100ps
module eeprom_select_lock_tb import eeprom_cfg_pkg::*;;
	localparam logic [3:0] DEV = 4'h6; // arbitrary device type
	localparam int unsigned WRITE_CYCLES = 20;
	logic i_core_clk = 1'h0;
	logic i_resetn;
	logic i_scl, m_oe, o_sda_oe, o_sda_out, o_write_busy, o_array_write_start, o_array_write_lock, k;
	logic [2:0] o_cfg_addr;
	logic [7:0] o_array_write_data, rd;
	int num_errors = 0;
	int checks = 0;
	int bcnt = 0;
	int pulses = 0;
	// pulled up unless a party pulls it low
	wire logic i_sda = (m_oe || (o_sda_oe && !o_sda_out)) ? 1'h0 : 1'h1;
	always #20 i_core_clk = !i_core_clk;
	// tally busy cycles and launch pulses
	always @(posedge i_core_clk) begin
		bcnt += (o_write_busy === 1'h1);
		pulses += (o_array_write_start === 1'h1);
	end
	i2c_master_model m (.o_scl(i_scl), .o_sda_oe(m_oe), .i_sda(i_sda));
	eeprom_select_lock #(.DEVICE_TYPE(DEV), .WRITE_CYCLES(WRITE_CYCLES)) dut (.*);
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("%0d checks, %0d mismatches", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// start, c bytes from the top of b, stop; answers compared as a vector
	task automatic frame(input string n, input logic [31:0] b, input int c, input logic [3:0] e);
		logic [3:0] a;
		a = 4'h0;
		m.start();
		for (int i = 0; i < c; i++)
			m.put(b[31 - 8 * i -: 8], a[3 - i]);
		m.stop();
		chk(n, {4'h0, a}, {4'h0, e});
	endtask
	// let a write cycle begin, then wait, bounded, for it to end
	task automatic settle();
		for (int i = 0; i < 100; i++) begin
			@(posedge i_core_clk);
			#2;
			if (i > 4 && o_write_busy === 1'h0) begin
				// the reported settings follow the stored byte one cycle later
				@(posedge i_core_clk);
				#2;
				return;
			end
		end
		num_errors++;
		wrap_up();
	endtask
	// stored configuration, write cycles run and launches so far
	task automatic look(input string n, input logic [2:0] a, input logic l, input int w, input int p);
		chk(n, {4'h0, o_cfg_addr, o_array_write_lock}, {4'h0, a, l});
		chk("busy_cycles", 8'(bcnt), 8'(w * WRITE_CYCLES));
		chk("launches", 8'(pulses), 8'(p));
	endtask
	initial begin
		// a real falling edge, so every asynchronous reset branch runs
		#1 i_resetn = 1'h0;
		repeat (12) @(posedge i_core_clk);
		#2 i_resetn = 1'h1;
		#7;
		look("reset_cfg", CFG_ADDR_FACTORY, CFG_LOCK_FACTORY, 0, 0);
		for (int c = 1; c < 8; c++)
			frame("wrong_ce", {DEV, 3'(c), 1'h0, 24'h0}, 1, 4'h0);
		frame("wrong_type", {~DEV, 3'h0, 1'h1, 24'h0}, 1, 4'h0);
		$display("select test done");
		frame("cfg_write", {DEV, 3'h0, 1'h0, 24'hf000fb}, 4, 4'hf);
		frame("select_busy", {DEV, 3'h0, 1'h0, 24'h0}, 1, 4'h0);
		settle();
		look("cfg_new", 3'h5, 1'h1, 1, 0);
		frame("old_address", {DEV, 3'h0, 1'h0, 24'h0}, 1, 4'h0);
		m.start();
		m.put({DEV, 3'h5, 1'h1}, k);
		m.get(rd);
		m.stop();
		chk("read_ack", 8'(k), 8'h01);
		chk("read_cfg", rd, 8'h0b);
		$display("config test done");
		frame("locked_write", {DEV, 3'h5, 1'h0, 24'h01203c}, 4, 4'he);
		settle();
		look("locked", 3'h5, 1'h1, 1, 0);
		frame("unlock", {DEV, 3'h5, 1'h0, 24'h80000a}, 4, 4'hf);
		settle();
		look("unlocked", 3'h5, 1'h0, 2, 0);
		frame("array_write", {DEV, 3'h5, 1'h0, 24'h01205a}, 4, 4'hf);
		settle();
		look("array", 3'h5, 1'h0, 3, 1);
		chk("write_data", o_array_write_data, 8'h5a);
		$display("lock test done");
		wrap_up();
	end
endmodule
